// File: hw/clk_sel_params.svh
// Constants for the system clock reference selector: register map, fields, timing.
// Assumes inclusion by bare name from design files.
`ifndef CLK_SEL_PARAMS_SVH
`define CLK_SEL_PARAMS_SVH
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_EVENTS      12'h008
`define REG_MASK        12'h00c
`define REG_PORT_EN     12'h010
`define REG_PORT_XC     12'h014
`define REG_PORT_NET    12'h018
`define CTRL_PRI_LSB    0
`define CTRL_SEC_LSB    4
`define CTRL_TRIB_BIT   8
`define CTRL_RESET      32'h0000_0088
`define SRC_INTERNAL    4'h8
`define EV_PRI_FAIL     0
`define EV_SEC_FAIL     1
`define EV_MISCONFIG    2
`define EV_SWITCH       3
`define EV_WIDTH        4
`define ACT_WINDOW      16'd256
`define DIV_HALF        8'd10
`endif

// File: hw/clk_sel_pkg.sv
// Types shared by the system clock reference selector.
// Assumes nothing beyond a SystemVerilog compiler.
package clk_sel_pkg;
   typedef enum logic [1:0] {
      ref_primary,
      ref_secondary,
      ref_holdover
   } ref_state_t;
endpackage

// File: hw/activity_monitor.sv
// Loss-of-activity monitor for one synchronised reference clock.
// Assumes ref_sync is already two-flop synchronised to pclk.
`timescale 1ns/10ps
`include "clk_sel_params.svh"
module activity_monitor #(
   parameter logic [15:0] WINDOW = `ACT_WINDOW
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ref_sync,
   output logic      alive
);
   typedef struct packed {
      logic        last;
      logic        seen;
      logic [15:0] count;
      logic        alive;
   } mon_state_t;
   mon_state_t s;
   mon_state_t next_s;
   always_comb begin
      next_s = s;
      next_s.last = ref_sync;
      if (ref_sync && !s.last) begin
         next_s.seen = 1'b1;
      end
      if (s.count == WINDOW - 16'h0001) begin
         next_s.count = 16'h0000;
         next_s.alive = s.seen || (ref_sync && !s.last);
         next_s.seen  = 1'b0;
      end else begin
         next_s.count = s.count + 16'h0001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign alive = s.alive;
endmodule

// File: hw/glitchless_mux.sv
// Divides the chosen reference into the system tick; holdover keeps the last period.
// Assumes edge pulses of all candidates are already in the pclk domain.
`timescale 1ns/10ps
module glitchless_mux #(
   parameter int N = 9
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [N-1:0]  edge_in,
   input  wire logic [3:0]    sel,
   input  wire logic          hold,
   output logic               sys_clk
);
   typedef struct packed {
      logic [15:0] period;
      logic [15:0] since;
      logic [15:0] hcount;
      logic [1:0]  gap;
      logic        clk;
   } mux_state_t;
   mux_state_t s;
   mux_state_t next_s;
   logic       pick;
   always_comb begin
      pick = (sel < 4'(N)) ? edge_in[sel] : 1'b0;
      next_s = s;
      next_s.since = s.since + 16'h0001;
      next_s.gap   = (s.gap == 2'h3) ? 2'h3 : s.gap + 2'h1;
      // whole cycles only
      // An edge too close to the last toggle is skipped, trading one lost edge
      // on switchover for a minimum pulse width of four pclk cycles
      if (!hold && pick) begin
         next_s.period = s.since + 16'h0001;
         next_s.since  = 16'h0000;
         next_s.hcount = 16'h0000;
         if (s.gap == 2'h3) begin
            next_s.clk = ~s.clk;
            next_s.gap = 2'h0;
         end
      end else if (hold) begin
         if (s.hcount + 16'h0001 >= s.period && s.gap == 2'h3) begin
            next_s.hcount = 16'h0000;
            next_s.clk    = ~s.clk;
            next_s.gap    = 2'h0;
         end else begin
            next_s.hcount = s.hcount + 16'h0001;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign sys_clk = s.clk;
endmodule

// File: hw/sys_clock_selector.sv
// Top: APB slave, eight port clocks plus internal oscillator, interrupt out.
// Assumes port clocks are asynchronous and slow against pclk.
`timescale 1ns/10ps
`include "clk_sel_params.svh"
module sys_clock_selector #(
   parameter int          NPORT  = 8,
   parameter logic [15:0] WINDOW = `ACT_WINDOW
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [NPORT-1:0] port_clk,
   input  wire logic             osc_clk,
   output logic                  sys_clk,
   output logic      [NPORT-1:0] port_tx_slave,
   output logic      [1:0]       ref_state,
   output logic                  alarm,
   output logic                  irq
);
   localparam int N = NPORT + 1;
   typedef struct packed {
      logic [N-1:0]          meta;
      logic [N-1:0]          sync;
      logic [N-1:0]          last;
      logic [3:0]            pri;
      logic [3:0]            sec;
      logic                  trib;
      logic [NPORT-1:0]      en;
      logic [NPORT-1:0]      xc;
      logic [NPORT-1:0]      net;
      logic [`EV_WIDTH-1:0]  events;
      logic [`EV_WIDTH-1:0]  mask;
      clk_sel_pkg::ref_state_t st;
      logic [31:0]           rdata;
   } top_state_t;
   top_state_t   s;
   top_state_t   next_s;
   logic [N-1:0] alive;
   logic [N-1:0] edges;
   logic         pri_ok;
   logic         sec_ok;
   logic         misconf;
   logic [3:0]   sel;
   logic         wr;
   logic         rd;
   logic [`EV_WIDTH-1:0] ev_set;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_mon
         activity_monitor #(.WINDOW(WINDOW)) u_mon (
            .pclk     (pclk),
            .presetn  (presetn),
            .ref_sync (s.sync[g]),
            .alive    (alive[g])
         );
      end
   endgenerate

   // A source is usable if alive and its port qualifies
   function automatic logic src_ok(input logic [3:0] idx, input top_state_t t,
                                   input logic [N-1:0] live);
      logic q;
      q = 1'b0;
      if (idx == `SRC_INTERNAL) begin
         q = live[NPORT];
      end else if (idx < 4'(NPORT)) begin
         if (t.trib) begin
            q = t.en[idx[2:0]] && t.xc[idx[2:0]] && live[idx];
         end else begin
            q = t.en[idx[2:0]] && t.net[idx[2:0]] && live[idx];
         end
      end
      return q;
   endfunction

   // Combination check of the pairing table
   function automatic logic pair_bad(input top_state_t t);
      logic b;
      b = 1'b0;
      if (t.pri == `SRC_INTERNAL) begin
         b = (t.sec != `SRC_INTERNAL);
      end else if (t.pri >= 4'(NPORT)) begin
         b = 1'b1;
      end else if (t.trib) begin
         b = (t.sec >= 4'(NPORT)) || !t.xc[t.sec[2:0]];
      end else if (t.sec != `SRC_INTERNAL) begin
         b = (t.sec >= 4'(NPORT)) || t.xc[t.sec[2:0]];
      end
      return b;
   endfunction

   assign edges = s.sync & ~s.last;
   assign wr    = psel && penable && pwrite;
   assign rd    = psel && penable && !pwrite;

   always_comb begin
      next_s = s;
      // Two-flop synchronisers for port and oscillator clocks
      next_s.meta = {osc_clk, port_clk};
      next_s.sync = s.meta;
      next_s.last = s.sync;
      pri_ok  = src_ok(s.pri, s, alive);
      sec_ok  = src_ok(s.sec, s, alive);
      misconf = pair_bad(s);
      ev_set  = '0;
      case (s.st)
         clk_sel_pkg::ref_primary: begin
            if (!pri_ok) begin
               next_s.st = sec_ok ? clk_sel_pkg::ref_secondary
                                  : clk_sel_pkg::ref_holdover;
               ev_set[`EV_SWITCH] = 1'b1;
            end
         end
         clk_sel_pkg::ref_secondary: begin
            if (pri_ok) begin
               next_s.st = clk_sel_pkg::ref_primary;
               ev_set[`EV_SWITCH] = 1'b1;
            end else if (!sec_ok) begin
               next_s.st = clk_sel_pkg::ref_holdover;
               ev_set[`EV_SWITCH] = 1'b1;
            end
         end
         default: begin
            if (pri_ok) begin
               next_s.st = clk_sel_pkg::ref_primary;
               ev_set[`EV_SWITCH] = 1'b1;
            end else if (sec_ok) begin
               next_s.st = clk_sel_pkg::ref_secondary;
               ev_set[`EV_SWITCH] = 1'b1;
            end
         end
      endcase
      ev_set[`EV_PRI_FAIL]  = !pri_ok;
      ev_set[`EV_SEC_FAIL]  = !sec_ok && !pri_ok;
      ev_set[`EV_MISCONFIG] = misconf;
      // Read of the event register clears it; a new event wins
      if (rd && paddr == `REG_EVENTS) begin
         next_s.events = ev_set;
      end else begin
         next_s.events = s.events | ev_set;
      end
      if (wr) begin
         if (paddr == `REG_CTRL) begin
            next_s.pri  = pwdata[`CTRL_PRI_LSB +: 4];
            next_s.sec  = pwdata[`CTRL_SEC_LSB +: 4];
            next_s.trib = pwdata[`CTRL_TRIB_BIT];
         end else if (paddr == `REG_MASK) begin
            next_s.mask = pwdata[`EV_WIDTH-1:0];
         end else if (paddr == `REG_PORT_EN) begin
            next_s.en = pwdata[NPORT-1:0];
         end else if (paddr == `REG_PORT_XC) begin
            next_s.xc = pwdata[NPORT-1:0];
         end else if (paddr == `REG_PORT_NET) begin
            next_s.net = pwdata[NPORT-1:0];
         end
      end
      next_s.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         if (paddr == `REG_CTRL) begin
            next_s.rdata = {23'h000000, s.trib, s.sec, s.pri};
         end else if (paddr == `REG_STATUS) begin
            next_s.rdata = {26'h0000000, misconf, sec_ok, pri_ok, 1'b0, s.st};
         end else if (paddr == `REG_EVENTS) begin
            next_s.rdata = {28'h0000000, s.events};
         end else if (paddr == `REG_MASK) begin
            next_s.rdata = {28'h0000000, s.mask};
         end else if (paddr == `REG_PORT_EN) begin
            next_s.rdata = {24'h000000, s.en};
         end else if (paddr == `REG_PORT_XC) begin
            next_s.rdata = {24'h000000, s.xc};
         end else if (paddr == `REG_PORT_NET) begin
            next_s.rdata = {24'h000000, s.net};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s      <= '0;
         s.pri  <= `SRC_INTERNAL;
         s.sec  <= `SRC_INTERNAL;
      end else begin
         s <= next_s;
      end
   end

   assign sel = (s.st == clk_sel_pkg::ref_secondary) ? s.sec : s.pri;

   glitchless_mux #(.N(N)) u_mux (
      .pclk    (pclk),
      .presetn (presetn),
      .edge_in (edges),
      .sel     ((sel == `SRC_INTERNAL) ? 4'(NPORT) : sel),
      .hold    (s.st == clk_sel_pkg::ref_holdover),
      .sys_clk (sys_clk)
   );

   always_comb begin
      port_tx_slave = s.xc;
      if (s.pri < 4'(NPORT)) begin
         port_tx_slave[s.pri[2:0]] = 1'b0;
      end
      if (s.sec < 4'(NPORT)) begin
         port_tx_slave[s.sec[2:0]] = 1'b0;
      end
   end

   assign ref_state = s.st;
   assign alarm     = |s.events[2:0];
   assign irq       = |(s.events & s.mask);
   assign prdata    = s.rdata;
   assign pready    = 1'b1;
   assign pslverr   = 1'b0;
endmodule

// File: dv/clk_sel_properties.sv
// Port-level assertions for the system clock reference selector.
// Assumes it is bound into sys_clock_selector and sees only its ports.
`timescale 1ns/10ps
module clk_sel_properties #(
   parameter int NPORT = 8
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic             sys_clk,
   input wire logic [NPORT-1:0] port_tx_slave,
   input wire logic [1:0]       ref_state,
   input wire logic             alarm,
   input wire logic             irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd = psel && penable && !pwrite;
   a_ready_no_error: assert property (pready && !pslverr)
      else $error("pready low or pslverr high");
   a_unmapped_zero: assert property (rd && paddr > 12'h018 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_alarm_sticky: assert property ($fell(alarm) |-> $past(rd && paddr == 12'h008))
      else $error("alarm dropped without events read");
   a_irq_sticky: assert property ($fell(irq) |-> $past(psel && penable))
      else $error("irq dropped without register access");
   a_slave_static: assert property ($changed(port_tx_slave) |-> $past(psel && penable && pwrite))
      else $error("slave set changed without write");
   a_state_legal: assert property (ref_state != 2'd3)
      else $error("illegal reference state");
   a_hold_alarm: assert property ($rose(ref_state == 2'd2) |-> ##[0:4] alarm)
      else $error("holdover without alarm");
   a_high_whole: assert property ($rose(sys_clk) |=> sys_clk [*3])
      else $error("runt high pulse");
   a_low_whole: assert property ($fell(sys_clk) |=> !sys_clk [*3])
      else $error("runt low pulse");
endmodule

// File: dv/ref_clock_model.sv
// Port recovered clocks and internal oscillator feeding the selector.
// Assumes run bits are set by the bench; a stopped source holds low.
`timescale 1ns/10ps
module ref_clock_model (
   input  wire logic [8:0] run,
   output logic      [7:0] port_clk,
   output logic            osc_clk
);
   logic ph  = 1'b0;
   logic oph = 1'b0;
   always #150 ph = ~ph;
   always #125 oph = ~oph;
   // A dead line stands still rather than freezing mid-pulse
   assign port_clk = {8{ph}} & run[7:0];
   assign osc_clk = oph & run[8];
endmodule

// File: dv/tb.sv
// Self-checking bench for the system clock reference selector.
// Assumes the short monitor window keeps reference loss detection quick.
`timescale 1ns/10ps
`include "clk_sel_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [8:0]  run     = 9'h1ff;
   logic [31:0] seed    = 32'd58100;
   logic [31:0] prdata, m;
   logic        pready, pslverr, sys_clk, alarm, irq, osc_clk;
   logic [7:0]  port_clk, port_tx_slave;
   logic [1:0]  ref_state;
   logic [63:0] q[$];
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          n;
   always #12.5 pclk = ~pclk;
   ref_clock_model ref_clock_model_i (.*);
   sys_clock_selector #(.WINDOW(16'd16)) sys_clock_selector_i (.*);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] k);
      int i;
      if (!w) q.push_back({d, k});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         error_cnt++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wst(input logic [1:0] v);
      int i;
      for (i = 0; i < 3000 && ref_state !== v; i++) @(negedge pclk);
      if (i == 3000) begin
         error_cnt++;
         summarize();
      end
      xfer(0, `REG_STATUS, {30'h0, v}, 32'h3);
   endtask
   always @(posedge pclk) begin
      logic [63:0] e;
      if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         `CHK(prdata & e[31:0], e[63:32])
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, `REG_CTRL, `CTRL_RESET, 32'h1ff);
      xfer(1, 12'h020, 32'hffffffff, 32'h0);
      xfer(0, 12'h020, 32'h0, 32'hffffffff);
      wst(2'd0);
      xfer(1, `REG_PORT_EN, 32'hff, 32'h0);
      xfer(1, `REG_PORT_NET, 32'hfe, 32'h0);
      xfer(1, `REG_PORT_XC, 32'h0d, 32'h0);
      xfer(1, `REG_CTRL, 32'h10, 32'h0);
      @(negedge pclk);
      `CHK(port_tx_slave, 8'h0c)
      wst(2'd1);
      xfer(1, `REG_PORT_NET, 32'hff, 32'h0);
      wst(2'd0);
      xfer(0, `REG_EVENTS, 32'h0, 32'h0);
      xfer(0, `REG_EVENTS, 32'h0, 32'h3);
      @(negedge pclk);
      `CHK(alarm, 1'b0)
      `CHK(irq, 1'b0)
      m = (rnd() & 32'hf) | 32'h1;
      xfer(1, `REG_MASK, m, 32'h0);
      xfer(0, `REG_MASK, m, 32'hf);
      // Secondary lost while primary is healthy
      run <= 9'h1fd;
      repeat (100) @(posedge pclk);
      xfer(0, `REG_EVENTS, 32'h0, 32'h3);
      run <= 9'h1ff;
      repeat (100) @(posedge pclk);
      xfer(0, `REG_EVENTS, 32'h0, 32'h0);
      run <= 9'h1fe;
      wst(2'd1);
      @(negedge pclk);
      `CHK(alarm, 1'b1)
      `CHK(irq, 1'b1)
      run <= 9'h1fc;
      wst(2'd2);
      n = 0;
      repeat (240) @(negedge pclk) n += sys_clk;
      `CHK(n > 60 && n < 180, 1'b1)
      run <= 9'h1ff;
      wst(2'd0);
      xfer(1, `REG_PORT_XC, 32'h0f, 32'h0);
      xfer(1, `REG_CTRL, 32'h110, 32'h0);
      xfer(0, `REG_STATUS, 32'h0, 32'h20);
      summarize();
   end
endmodule
bind sys_clock_selector clk_sel_properties #(.NPORT(NPORT)) clk_sel_properties_i (.*);
